// ### verif/addr_decode_monitor.sv
// assertions on the matrix address decoder ports
`timescale 1ns/1ps
module addr_decode_monitor #(
    parameter int NUM_MASTERS = 6
) (
    // clock and control
    input wire logic                                 CLK,
    input wire logic                                 SYS_RST,
    input wire logic                                 CE,
    // requests and answers
    input wire addr_map_pkg::req_t [NUM_MASTERS-1:0]   M_REQ,
    input wire addr_map_pkg::route_t [NUM_MASTERS-1:0] M_ROUTE,
    input wire logic [NUM_MASTERS-1:0][7:0]          EXTERNAL_CHIP_SELECT_N,
    input wire logic [NUM_MASTERS-1:0]               M_ABORT,
    // status
    input wire logic                                 REMAP_ACTIVE,
    input wire addr_map_pkg::boot_src_t              BOOT_SOURCE,
    input wire addr_map_pkg::smc_cfg_t               SMC_BOOT_CFG
);
    import addr_map_pkg::*;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    logic       go;
    logic       zero;
    logic [3:0] bank;
    // master 0 stands for the boot masters; a_same_map ties master 1 to it
    assign go   = CE && M_REQ[0].valid;
    assign bank = M_REQ[0].addr[31:28];
    assign zero = M_REQ[0].addr[31:20] == 12'h000;
    a_ext_cs_onehot: assert property (go && bank inside {[4'h1:4'h7]} |=>
        EXTERNAL_CHIP_SELECT_N[0] == ~(8'h01 << ($past(bank) - 4'h1)))
        else $error("wrong external select");
    a_periph_bank: assert property (go && bank == 4'hf |=>
        M_ROUTE[0].target == TGT_PERIPH && !M_ABORT[0]) else $error("bank 15 not peripheral");
    a_unused_abort: assert property (go && bank inside {[4'h8:4'he]} |=>
        M_ABORT[0] && M_ROUTE[0].target == TGT_NONE && EXTERNAL_CHIP_SELECT_N[0] == 8'hff)
        else $error("unused bank not aborted");
    a_offset_kept: assert property (go |=>
        M_ROUTE[0].offset == $past(M_REQ[0].addr[27:0])) else $error("offset changed");
    a_remap_ram: assert property (go && zero && REMAP_ACTIVE |=>
        M_ROUTE[0].target == TGT_RAM0) else $error("remap not at zero");
    a_boot_rom: assert property (go && zero && !REMAP_ACTIVE &&
        BOOT_SOURCE == BOOT_FROM_ROM |=> M_ROUTE[0].target == TGT_ROM) else $error("no rom at zero");
    a_fixed_ram: assert property (go && M_REQ[0].addr[31:20] == 12'h002 |=>
        M_ROUTE[0].target == TGT_RAM0) else $error("ram base moved");
    a_same_map: assert property (CE && M_REQ[0] == M_REQ[1] |=>
        M_ROUTE[0] == M_ROUTE[1] && EXTERNAL_CHIP_SELECT_N[0] == EXTERNAL_CHIP_SELECT_N[1])
        else $error("masters decode apart");
    a_smc_default: assert property (BOOT_SOURCE == BOOT_FROM_EXTERNAL |->
        SMC_BOOT_CFG == 4'hb) else $error("bad static boot config");
    a_remap_cleared: assert property ($fell(SYS_RST) |-> !REMAP_ACTIVE)
        else $error("remap survives reset");
    a_ce_freeze: assert property (!CE |=> $stable(M_ROUTE) && $stable(REMAP_ACTIVE))
        else $error("state moved while disabled");
    c_ext: cover property (go && bank == 4'h7);
    c_abort: cover property (M_ABORT[0]);
    c_remap: cover property (go && zero && REMAP_ACTIVE);
    c_freeze: cover property (!CE && M_ABORT[0]);
endmodule : addr_decode_monitor
bind matrix_address_decode_boot_remap addr_decode_monitor #(.NUM_MASTERS(NUM_MASTERS))
    addr_decode_monitor_i (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .M_REQ(M_REQ),
    .M_ROUTE(M_ROUTE), .EXTERNAL_CHIP_SELECT_N(EXTERNAL_CHIP_SELECT_N), .M_ABORT(M_ABORT),
    .REMAP_ACTIVE(REMAP_ACTIVE), .BOOT_SOURCE(BOOT_SOURCE), .SMC_BOOT_CFG(SMC_BOOT_CFG));

// ### verif/bus_master_model.sv
// behavioural bus masters driving one request bus each
`timescale 1ns/1ps
module bus_master_model #(
    parameter int N = 6
) (
    // clock
    input  wire logic                clk,
    // request buses
    output addr_map_pkg::req_t [N-1:0] req
);
    import addr_map_pkg::*;
    initial req = '0;
    // idle masters show a toggled address so a stale one never decodes
    task automatic issue(input logic [N-1:0] mask, input logic [31:0] a);
        @(negedge clk);
        for (int m = 0; m < N; m++) begin
            req[m].valid = mask[m];
            req[m].addr  = mask[m] ? a : ~req[m].addr;
        end
    endtask : issue
endmodule : bus_master_model

// ### verif/tb_matrix_address_decode_boot_remap.sv
// self-checking bench for the matrix address decoder
`timescale 1ns/1ps
module tb_matrix_address_decode_boot_remap;
    import addr_map_pkg::*;
    typedef struct packed {
        logic [31:0] addr;
        target_t     tgt;
        logic [7:0]  cs;
    } row_t;
    logic              clk;
    logic              sys_rst;
    logic              ce;
    logic              boot_pin;
    logic              remap_set;
    logic              remap_clear;
    req_t [5:0]        m_req;
    route_t [5:0]      m_route;
    logic [5:0][7:0]   cs_n;
    logic [5:0]        m_abort;
    logic              remap_active;
    boot_src_t         boot_source;
    smc_cfg_t          smc_cfg;
    logic [31:0]       abort_addr;
    logic [3:0]        abort_master;
    target_t           exp;
    int                n_errors = 0;
    int                samples_checked = 0;
    row_t              rows [11] = '{
        '{32'h0000_0010, TGT_ROM, 8'hff}, '{32'h0010_0004, TGT_ROM, 8'hff},
        '{32'h0020_0000, TGT_RAM0, 8'hff}, '{32'h0030_0008, TGT_RAM1, 8'hff},
        '{32'h0050_0000, TGT_USB_HOST, 8'hff}, '{32'h0040_0000, TGT_NONE, 8'hff},
        '{32'h1000_0000, TGT_EXTERNAL, 8'hfe}, '{32'h7fff_fffc, TGT_EXTERNAL, 8'hbf},
        '{32'h8000_0000, TGT_NONE, 8'hff}, '{32'he000_0000, TGT_NONE, 8'hff},
        '{32'hffff_fff0, TGT_PERIPH, 8'hff}};
    bus_master_model #(.N(6)) bus_master_model_i (.clk(clk), .req(m_req));
    matrix_address_decode_boot_remap matrix_address_decode_boot_remap_i (
        .CLK(clk), .SYS_RST(sys_rst), .CE(ce), .BOOT_SELECT_PIN(boot_pin),
        .REMAP_SET(remap_set), .REMAP_CLEAR(remap_clear), .M_REQ(m_req), .M_ROUTE(m_route),
        .EXTERNAL_CHIP_SELECT_N(cs_n), .M_ABORT(m_abort), .REMAP_ACTIVE(remap_active),
        .BOOT_SOURCE(boot_source), .SMC_BOOT_CFG(smc_cfg), .ABORT_ADDR(abort_addr),
        .ABORT_MASTER(abort_master));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
        end
    endtask : check
    // request then idle, so the answer is looked at while it stands
    task automatic send(input logic [5:0] mask, input logic [31:0] a);
        bus_master_model_i.issue(mask, a);
        bus_master_model_i.issue(6'h00, 32'h0);
    endtask : send
    task automatic do_reset(input logic pin);
        @(negedge clk);
        sys_rst  = 1'b1;
        boot_pin = pin;
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
    endtask : do_reset
    task automatic pulse(input logic set);
        @(negedge clk);
        remap_set   = set;
        remap_clear = !set;
        @(negedge clk);
        remap_set   = 1'b0;
        remap_clear = 1'b0;
    endtask : pulse
    task automatic end_sim;
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #5000;
        n_errors++;
        end_sim();
    end
    initial begin
        sys_rst     = 1'b1;
        ce          = 1'b1;
        boot_pin    = 1'b1;
        remap_set   = 1'b0;
        remap_clear = 1'b0;
        do_reset(1'b1);
        check(remap_active, 1'b0);
        check(boot_source, BOOT_FROM_ROM);
        for (int r = 0; r < 11; r++) begin
            send(6'h3f, rows[r].addr);
            for (int m = 0; m < 6; m++) begin
                exp = (m > 1 && rows[r].addr[31:20] == 12'h000) ? TGT_NONE : rows[r].tgt;
                check(m_route[m].target, exp);
                check(m_abort[m], exp == TGT_NONE);
                check(cs_n[m], rows[r].cs);
                check(m_route[m].offset, rows[r].addr[27:0]);
                check(m_route[m].valid, 1'b1);
            end
        end
        $display("test map_rows done");
        // masters 3 and 5 abort together: the lower one is recorded
        send(6'h28, 32'h8000_0004);
        check(abort_addr, 32'h8000_0004);
        check(abort_master, 4'h3);
        @(negedge clk);
        check(m_abort[3], 1'b0);
        check(m_route[3].valid, 1'b0);
        $display("test abort_capture done");
        pulse(1'b1);
        check(remap_active, 1'b1);
        send(6'h03, 32'h0000_0040);
        check(m_route[1].target, TGT_RAM0);
        send(6'h01, 32'h0010_0000);
        check(m_route[0].target, TGT_ROM);
        do_reset(1'b0);
        check(remap_active, 1'b0);
        check(smc_cfg, 4'hb);
        send(6'h01, 32'h0000_0000);
        check(m_route[0].target, TGT_EXTERNAL);
        check(cs_n[0], 8'hfe);
        pulse(1'b1);
        pulse(1'b0);
        check(boot_source, BOOT_FROM_EXTERNAL);
        $display("test boot_remap done");
        // enable low: the standing abort is held, request and remap are ignored
        bus_master_model_i.issue(6'h01, 32'h9000_0000);
        @(negedge clk);
        ce = 1'b0;
        bus_master_model_i.issue(6'h01, 32'h1000_0000);
        pulse(1'b1);
        check(m_abort[0], 1'b1);
        check(abort_addr, 32'h9000_0000);
        check(remap_active, 1'b0);
        ce = 1'b1;
        send(6'h01, 32'h0000_0000);
        check(m_route[0].target, TGT_EXTERNAL);
        check(remap_active, 1'b0);
        $display("test clock_enable done");
        end_sim();
    end
endmodule : tb_matrix_address_decode_boot_remap

// ### verilog/addr_map_pkg.sv
// types shared by the matrix address decoder files
package addr_map_pkg;

    typedef enum logic [2:0] {
        TGT_NONE,
        TGT_ROM,
        TGT_RAM0,
        TGT_RAM1,
        TGT_USB_HOST,
        TGT_EXTERNAL,
        TGT_PERIPH
    } target_t;

    typedef enum logic [1:0] {
        BOOT_FROM_ROM,
        BOOT_FROM_EXTERNAL,
        BOOT_FROM_RAM
    } boot_src_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } req_t;

    typedef struct packed {
        logic        valid;
        logic        abort;
        target_t     target;
        logic [2:0]  cs_index;
        logic [27:0] offset;
    } route_t;

    typedef struct packed {
        logic       byte_select;
        logic [1:0] bus_width;
        logic       strobe_by_cs;
    } smc_cfg_t;

endpackage : addr_map_pkg

// ### verilog/addr_map_regs.svh
// address map constants for the matrix first-level decoder
`ifndef ADDR_MAP_REGS_SVH
`define ADDR_MAP_REGS_SVH

// bank split: sixteen banks of 256 Mbytes, picked by addr[31:28]
`define BANK_MSB            31
`define BANK_LSB            28
`define BANK_W              4
`define BANK_INTERNAL       4'h0
`define BANK_EXT_FIRST      4'h1
`define BANK_EXT_LAST       4'h7
`define BANK_PERIPH         4'hf

// second level inside bank 0: 1-Mbyte regions, picked by addr[27:20]
`define REGION_MSB          27
`define REGION_LSB          20
`define REGION_W            8
`define REGION_BOOT         8'h00
`define REGION_ROM          8'h01
`define REGION_RAM0         8'h02
`define REGION_RAM1         8'h03
`define REGION_USB_HOST     8'h05

// fixed base addresses of the internal blocks
`define BASE_BOOT           32'h0000_0000
`define BOOT_REGION_TOP     32'h000f_ffff
`define BASE_ROM            32'h0010_0000
`define BASE_RAM0           32'h0020_0000
`define BASE_RAM1           32'h0030_0000
`define BASE_USB_HOST       32'h0050_0000

// offset inside a bank
`define OFFSET_W            28

// external chip selects
`define EXT_CS_W            8
`define EXT_CS_IDX_W        3
`define EXT_CS_BOOT         3'h0
`define EXT_CS_NONE_N       8'hff

// static memory controller defaults for external boot
`define SMC_BYTE_SELECT     1'b1
`define SMC_WIDTH_16        2'h1
`define SMC_STROBE_BY_CS    1'b1

// sampled boot level meaning
`define BOOT_LEVEL_ROM      1'b1

`endif

// ### verilog/matrix_address_decode_boot_remap.sv
// first-level address decoder of the bus matrix with boot select and remap
`timescale 1ns/1ps
`include "addr_map_regs.svh"

// Behaviour
// - sixteen 256-Mbyte banks chosen by the top four address bits
// - banks 1 to 7 go external, chip selects 0 upward in order
// - bank 0 holds internal memories, decoded in 1-Mbyte regions
// - bank 15 goes to the peripheral bridge
// - access to unassigned areas answers with abort
// - every master has its own decoder, identical outside the zero region
// - processor masters see boot ROM, external boot or RAM at zero
// - ROM, both RAMs and USB host stay at fixed bases
// - boot memory is present at zero from the first access
// - remap set puts first RAM at zero and ignores boot pin
// - boot pin sampled at reset picks the zero-region memory
// - boot level 1 with remap clear maps ROM at zero
// - boot level 0 with remap clear maps chip select 0 at zero
// - external boot gives byte select, 16-bit bus, strobes by select
// - blocks outside remap stay reachable at their bases
// - external chip selects 0 to 6 each own a 256-Mbyte window
module matrix_address_decode_boot_remap #(
    parameter int                     NUM_MASTERS  = 6,
    parameter logic [NUM_MASTERS-1:0] BOOT_MASTERS = 6'h03
) (
    // clock, reset, enable
    input  wire logic                                      CLK,
    input  wire logic                                      SYS_RST,
    input  wire logic                                      CE,
    // boot strap and remap control
    input  wire logic                                      BOOT_SELECT_PIN,
    input  wire logic                                      REMAP_SET,
    input  wire logic                                      REMAP_CLEAR,
    // master requests
    input  wire addr_map_pkg::req_t [NUM_MASTERS-1:0]      M_REQ,
    // per-master routing answers
    output addr_map_pkg::route_t [NUM_MASTERS-1:0]         M_ROUTE,
    output logic [NUM_MASTERS-1:0][`EXT_CS_W-1:0]          EXTERNAL_CHIP_SELECT_N,
    output logic [NUM_MASTERS-1:0]                         M_ABORT,
    // boot and remap status
    output logic                                           REMAP_ACTIVE,
    output addr_map_pkg::boot_src_t                        BOOT_SOURCE,
    output addr_map_pkg::smc_cfg_t                         SMC_BOOT_CFG,
    // last aborted access
    output logic [31:0]                                    ABORT_ADDR,
    output logic [3:0]                                     ABORT_MASTER
);
    import addr_map_pkg::*;

    // the decoder has only four bits of master number to report
    generate
        if (NUM_MASTERS < 1 || NUM_MASTERS > 16) begin : g_bad_masters
            $error("NUM_MASTERS must lie between 1 and 16");
        end
    endgenerate

    typedef enum {
        ST_BOOT,
        ST_REMAPPED
    } state_t;

    state_t    state_reg;
    state_t    state_next;
    logic      boot_level_reg;
    boot_src_t boot_src_reg;
    boot_src_t boot_src_next;
    smc_cfg_t  smc_cfg_reg;
    smc_cfg_t  smc_cfg_next;
    logic [31:0] abort_addr_reg;
    logic [3:0]  abort_master_reg;

    route_t [NUM_MASTERS-1:0] route_next;
    route_t [NUM_MASTERS-1:0] route_reg;

    // decode one address; the zero region only remaps for boot masters
    function automatic route_t decode_addr(
        input logic [31:0] addr,
        input logic        req_valid,
        input logic        boot_master,
        input boot_src_t   boot_src
    );
        route_t                  r;
        logic [`BANK_W-1:0]      bank;
        logic [`REGION_W-1:0]    region;
        r        = '0;
        bank     = addr[`BANK_MSB:`BANK_LSB];
        region   = addr[`REGION_MSB:`REGION_LSB];
        r.valid  = req_valid;
        r.offset = addr[`OFFSET_W-1:0];
        r.target = TGT_NONE;
        if (bank == `BANK_INTERNAL) begin
            // second level decode, 1-Mbyte per region
            case (region)
                `REGION_BOOT: begin
                    if (!boot_master) begin
                        r.target = TGT_NONE;
                    end else begin
                        case (boot_src)
                            BOOT_FROM_RAM: begin
                                r.target = TGT_RAM0;
                            end
                            BOOT_FROM_ROM: begin
                                r.target = TGT_ROM;
                            end
                            BOOT_FROM_EXTERNAL: begin
                                r.target   = TGT_EXTERNAL;
                                r.cs_index = `EXT_CS_BOOT;
                            end
                            default: begin
                                r.target = TGT_NONE;
                            end
                        endcase
                    end
                end
                // fixed bases, untouched by remap or boot level
                `REGION_ROM: begin
                    r.target = TGT_ROM;
                end
                `REGION_RAM0: begin
                    r.target = TGT_RAM0;
                end
                `REGION_RAM1: begin
                    r.target = TGT_RAM1;
                end
                `REGION_USB_HOST: begin
                    r.target = TGT_USB_HOST;
                end
                default: begin
                    r.target = TGT_NONE;
                end
            endcase
        end else if (bank >= `BANK_EXT_FIRST && bank <= `BANK_EXT_LAST) begin
            // whole bank is the window of one select
            r.target   = TGT_EXTERNAL;
            r.cs_index = `EXT_CS_IDX_W'(bank - `BANK_EXT_FIRST);
        end else if (bank == `BANK_PERIPH) begin
            r.target = TGT_PERIPH;
        end else begin
            r.target = TGT_NONE;
        end
        r.abort = req_valid && (r.target == TGT_NONE);
        if (!req_valid) begin
            r.target = TGT_NONE;
        end
        return r;
    endfunction : decode_addr

    // boot strap: the pin is caught on each reset cycle, held afterwards
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            boot_level_reg <= BOOT_SELECT_PIN;
        end
    end

    // remap control; set wins over clear in the same cycle
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_BOOT: begin
                if (REMAP_SET) begin
                    state_next = ST_REMAPPED;
                end
            end
            ST_REMAPPED: begin
                if (REMAP_CLEAR && !REMAP_SET) begin
                    state_next = ST_BOOT;
                end
            end
            default: begin
                state_next = ST_BOOT;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_reg <= ST_BOOT;
        end else if (CE) begin
            state_reg <= state_next;
        end
    end

    // zero-region owner; while in reset the pin is used directly so the
    // first fetch after release already sees the strapped memory
    always_comb begin
        if (SYS_RST) begin
            boot_src_next = (BOOT_SELECT_PIN == `BOOT_LEVEL_ROM) ?
                            BOOT_FROM_ROM : BOOT_FROM_EXTERNAL;
        end else if (state_next == ST_REMAPPED) begin
            boot_src_next = BOOT_FROM_RAM;
        end else if (boot_level_reg == `BOOT_LEVEL_ROM) begin
            boot_src_next = BOOT_FROM_ROM;
        end else begin
            boot_src_next = BOOT_FROM_EXTERNAL;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST || CE) begin
            boot_src_reg <= boot_src_next;
        end
    end

    // static controller defaults that let an external 16-bit part boot;
    // software reprograms the controller itself later
    always_comb begin
        smc_cfg_next              = '0;
        smc_cfg_next.byte_select  = `SMC_BYTE_SELECT;
        smc_cfg_next.bus_width    = `SMC_WIDTH_16;
        smc_cfg_next.strobe_by_cs = `SMC_STROBE_BY_CS;
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            smc_cfg_reg <= smc_cfg_next;
        end
    end

    // one decoder and output stage per master; decoders differ only by BOOT_MASTERS
    genvar m;
    generate
        for (m = 0; m < NUM_MASTERS; m++) begin : g_master
            always_comb begin
                route_next[m] = decode_addr(M_REQ[m].addr, M_REQ[m].valid,
                                            BOOT_MASTERS[m], boot_src_reg);
            end

            route_stage u_route_stage (
                .clk        (CLK),
                .rst        (SYS_RST),
                .ce         (CE),
                .route_next (route_next[m]),
                .route_reg  (route_reg[m]),
                .cs_n_reg   (EXTERNAL_CHIP_SELECT_N[m])
            );

            assign M_ABORT[m] = route_reg[m].abort;
        end
    endgenerate

    assign M_ROUTE = route_reg;

    // capture the last aborted access; lowest master wins a tie, which
    // loses the others but keeps the capture cheap
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            abort_addr_reg   <= '0;
            abort_master_reg <= '0;
        end else if (CE) begin
            for (int i = NUM_MASTERS - 1; i >= 0; i--) begin
                if (route_next[i].abort) begin
                    abort_addr_reg   <= M_REQ[i].addr;
                    abort_master_reg <= 4'(i);
                end
            end
        end
    end

    assign ABORT_ADDR   = abort_addr_reg;
    assign ABORT_MASTER = abort_master_reg;

    assign REMAP_ACTIVE = (state_reg == ST_REMAPPED);
    assign BOOT_SOURCE  = boot_src_reg;
    assign SMC_BOOT_CFG = smc_cfg_reg;

endmodule : matrix_address_decode_boot_remap

// ### verilog/route_stage.sv
// output register stage holding one master's routing answer
`timescale 1ns/1ps
`include "addr_map_regs.svh"

module route_stage (
    // clock, reset and enable
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    // decoded answer for this cycle
    input  wire addr_map_pkg::route_t route_next,
    // registered answer
    output addr_map_pkg::route_t      route_reg,
    output logic [`EXT_CS_W-1:0]      cs_n_reg
);
    import addr_map_pkg::*;

    logic [`EXT_CS_W-1:0] cs_n_next;

    always_comb begin
        cs_n_next = `EXT_CS_NONE_N;
        if (route_next.valid && route_next.target == TGT_EXTERNAL) begin
            cs_n_next[route_next.cs_index] = 1'b0;
        end
    end

    // answer stands until the next enabled cycle; idle cycles clear its valid, abort and target
    always_ff @(posedge clk) begin
        if (rst) begin
            route_reg <= '0;
        end else if (ce) begin
            route_reg <= route_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cs_n_reg <= `EXT_CS_NONE_N;
        end else if (ce) begin
            cs_n_reg <= cs_n_next;
        end
    end

endmodule : route_stage
